/* File: hw/cwd_decoder.sv */
// first configuration word fetch, decode and start-up sequencing
`timescale 1ns/100ps
// Summary of operation
// - a programmed bit reads 0, unprogrammed reads 1; erased word is all ones.
// - the configuration word is fetched from program memory address 2007h.
// - configuration space 2000h-3FFFh is reachable only in programming mode.
// - the two unimplemented top bits always read back as 1.
// - bit 13 at 1 disables debugger; at 0 programming pins belong to it.
// - bit 12 at 1 makes a port pin the low-voltage programming input.
// - bit 11 enables the fail-safe clock monitor when 1.
// - bit 10 enables internal/external clock switchover when 1.
// - brown-out field: 11 on, 10 off in sleep, 01 software, 00 off.
// - bit 7 at 0 protects data memory.
// - enabled power-up timer holds reset 64 ms, on power-up and after a brown-out.
// - start-up timer holds reset until the crystal oscillator is stable.
// - a brown-out resets the device, stretched by the power-up timer.
// - sleep ends on external reset, watchdog wake-up or interrupt.
// - bit 6 at 0 protects program memory.
// - bit 5 at 1 makes the shared pin the external reset input.
// - bit 4 at 0 enables the power-up timer.
// - bit 3 at 1 enables the watchdog, else software may enable it.
module cwd_decoder #(
    parameter int POWERUP_TIMER_CYCLES = cwd_pkg::POWERUP_TIMER_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        progMode,
    output logic [13:0]      memAddr,
    input  wire logic [13:0] memData,
    input  wire logic        oscStable,
    input  wire logic        extResetPin,
    input  wire logic        brownoutDet,
    input  wire logic        wdtWake,
    input  wire logic        irqWake,
    input  wire logic        sleepReq,
    input  wire logic        softBrownoutEnable,
    input  wire logic        softWatchdogEnable,
    input  wire logic        cfgRdEn,
    input  wire logic [13:0] cfgRdAddr,
    output logic [15:0]      configWordOne,
    output logic             cfgSpaceGrant,
    output logic             debugEnable,
    output logic             lowVoltProgEnable,
    output logic             clockMonitorEnable,
    output logic             clockSwitchoverEnable,
    output logic [1:0]       brownoutModeSel,
    output logic             brownoutActive,
    output logic             dataProtect,
    output logic             programProtect,
    output logic             extResetPinEnable,
    output logic             powerupTimerEnable,
    output logic             watchdogEnable,
    output logic             coreReset,
    output logic             sleeping
);
    localparam logic [31:0] OST_LAST  = 32'(cwd_pkg::OST_CYCLES - 1);
    localparam logic [31:0] POWERUP_TIMER_LAST = 32'(POWERUP_TIMER_CYCLES - 1);

    cwd_pkg::cwd_state_e state_ff, nxt_state;
    logic [15:0] word_ff, nxt_word;
    logic [31:0] cnt_ff, nxt_cnt;
    logic        powerUp_ff, nxt_powerUp;
    logic        rdGrant_ff, nxt_rdGrant;
    logic [15:0] rdData_ff, nxt_rdData;
    logic        extRstSync;
    logic        borSync;
    logic        wdtSync;
    logic        irqSync;
    logic        oscSync;
    logic        extRst;
    logic        borTrip;
    logic        wake;

    cwd_sync u_sync_ext_reset_pin (.mclk(mclk), .rst_n(rst_n), .din(extResetPin), .dout(extRstSync));
    cwd_sync u_sync_bor  (.mclk(mclk), .rst_n(rst_n), .din(brownoutDet), .dout(borSync));
    cwd_sync u_sync_wdt  (.mclk(mclk), .rst_n(rst_n), .din(wdtWake),     .dout(wdtSync));
    cwd_sync u_sync_irq  (.mclk(mclk), .rst_n(rst_n), .din(irqWake),     .dout(irqSync));
    cwd_sync u_sync_osc  (.mclk(mclk), .rst_n(rst_n), .din(oscStable),   .dout(oscSync));

    // external reset ignored unless the shared pin is configured for it
    // an external reset may not cut the oscillator start-up short
    assign extRst = extRstSync && word_ff[cwd_pkg::B_EXT_RESET_PIN_ENABLE]
                    && state_ff != cwd_pkg::ST_FETCH && state_ff != cwd_pkg::ST_OST;

    // brown-out detector gating by mode
    always_comb begin
        case (word_ff[cwd_pkg::B_BOR_HI:cwd_pkg::B_BOR_LO])
            cwd_pkg::BOR_ON:   borTrip = borSync;
            cwd_pkg::BOR_RUN:  borTrip = borSync && state_ff != cwd_pkg::ST_SLEEP;
            cwd_pkg::BOR_SOFT: borTrip = borSync && softBrownoutEnable;
            default:           borTrip = 1'b0;
        endcase
    end

    assign wake = extRst || wdtSync || irqSync;

    always_comb begin
        nxt_state   = state_ff;
        nxt_word    = word_ff;
        nxt_cnt     = cnt_ff;
        nxt_powerUp = powerUp_ff;
        case (state_ff)
            cwd_pkg::ST_FETCH: begin
                // word captured while the core is still held in reset
                nxt_word  = {cwd_pkg::ERASED_WORD[15:14], memData};
                nxt_cnt   = '0;
                nxt_state = cwd_pkg::ST_OST;
            end
            cwd_pkg::ST_OST: begin
                // count only once the oscillator reports stable
                nxt_cnt = oscSync ? cnt_ff + 32'h1 : '0;
                if (oscSync && cnt_ff >= OST_LAST) begin
                    nxt_cnt   = '0;
                    nxt_state = cwd_pkg::ST_POWERUP_TIMER;
                end
            end
            cwd_pkg::ST_POWERUP_TIMER: begin
                // timer runs on power-up, or to stretch a brown-out reset
                if (word_ff[cwd_pkg::B_POWERUP_TIMER_ENABLE_N] || !powerUp_ff) begin
                    nxt_state   = cwd_pkg::ST_RUN;
                    nxt_powerUp = 1'b0;
                end else if (cnt_ff >= POWERUP_TIMER_LAST) begin
                    nxt_state   = cwd_pkg::ST_RUN;
                    nxt_powerUp = 1'b0;
                end else begin
                    nxt_cnt = cnt_ff + 32'h1;
                end
            end
            cwd_pkg::ST_RUN: begin
                if (sleepReq) begin
                    nxt_state = cwd_pkg::ST_SLEEP;
                end
            end
            cwd_pkg::ST_SLEEP: begin
                if (wake) begin
                    nxt_state = cwd_pkg::ST_RUN;
                end
            end
            default: nxt_state = cwd_pkg::ST_FETCH;
        endcase
        if (extRst) begin
            nxt_state = cwd_pkg::ST_POWERUP_TIMER;
            nxt_cnt   = '0;
        end
        if (borTrip && state_ff != cwd_pkg::ST_FETCH && state_ff != cwd_pkg::ST_OST) begin
            // brown-out reuses the power-up timer stretch
            nxt_state   = cwd_pkg::ST_POWERUP_TIMER;
            nxt_cnt     = '0;
            nxt_powerUp = 1'b1;
        end
    end

    // programming-mode-only read path to the configuration space
    always_comb begin
        nxt_rdGrant = progMode && cfgRdEn && cfgRdAddr >= cwd_pkg::CFG_SPACE_LO;
        nxt_rdData  = '0;
        if (nxt_rdGrant && cfgRdAddr == cwd_pkg::CFG_ADDR) begin
            nxt_rdData = word_ff;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_ff   <= cwd_pkg::ST_FETCH;
            word_ff    <= cwd_pkg::ERASED_WORD;
            cnt_ff     <= '0;
            powerUp_ff <= 1'b1;
            rdGrant_ff <= 1'b0;
            rdData_ff  <= '0;
        end else begin
            state_ff   <= nxt_state;
            word_ff    <= nxt_word;
            cnt_ff     <= nxt_cnt;
            powerUp_ff <= nxt_powerUp;
            rdGrant_ff <= nxt_rdGrant;
            rdData_ff  <= nxt_rdData;
        end
    end

    // decoded option flip-flops, only refreshed during oscillator start-up; reset, sleep and brown-out-active flags every cycle
    logic [10:0] opt_ff, nxt_opt;
    logic        coreRst_ff, nxt_coreRst;
    logic        sleep_ff, nxt_sleep;
    logic        borAct_ff, nxt_borAct;
    always_comb begin
        nxt_opt = opt_ff;
        if (state_ff == cwd_pkg::ST_OST) begin
            nxt_opt[0]   = !word_ff[cwd_pkg::B_DEBUG];
            nxt_opt[1]   = word_ff[cwd_pkg::B_LVP];
            nxt_opt[2]   = word_ff[cwd_pkg::B_FCM];
            nxt_opt[3]   = word_ff[cwd_pkg::B_CLOCK_SWITCHOVER_ENABLE];
            nxt_opt[5:4] = word_ff[cwd_pkg::B_BOR_HI:cwd_pkg::B_BOR_LO];
            nxt_opt[6]   = !word_ff[cwd_pkg::B_CPD];
            nxt_opt[7]   = !word_ff[cwd_pkg::B_CP];
            nxt_opt[8]   = word_ff[cwd_pkg::B_EXT_RESET_PIN_ENABLE];
            nxt_opt[9]   = !word_ff[cwd_pkg::B_POWERUP_TIMER_ENABLE_N];
            nxt_opt[10]  = word_ff[cwd_pkg::B_WATCHDOG_ENABLE];
        end
        nxt_coreRst = nxt_state != cwd_pkg::ST_RUN && nxt_state != cwd_pkg::ST_SLEEP;
        nxt_sleep   = nxt_state == cwd_pkg::ST_SLEEP;
        case (word_ff[cwd_pkg::B_BOR_HI:cwd_pkg::B_BOR_LO])
            cwd_pkg::BOR_ON:   nxt_borAct = 1'b1;
            cwd_pkg::BOR_RUN:  nxt_borAct = nxt_state != cwd_pkg::ST_SLEEP;
            cwd_pkg::BOR_SOFT: nxt_borAct = softBrownoutEnable;
            default:           nxt_borAct = 1'b0;
        endcase
    end

    logic wdtEn_ff, nxt_wdtEn;
    // software enable only counts when the config bit leaves it off
    assign nxt_wdtEn = opt_ff[10] || softWatchdogEnable;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            opt_ff     <= '0;
            coreRst_ff <= 1'b1;
            sleep_ff   <= 1'b0;
            borAct_ff  <= 1'b0;
            wdtEn_ff   <= 1'b0;
        end else begin
            opt_ff     <= nxt_opt;
            coreRst_ff <= nxt_coreRst;
            sleep_ff   <= nxt_sleep;
            borAct_ff  <= nxt_borAct;
            wdtEn_ff   <= nxt_wdtEn;
        end
    end

    logic [13:0] addr_ff;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            addr_ff <= cwd_pkg::CFG_ADDR;
        end else begin
            addr_ff <= cwd_pkg::CFG_ADDR;
        end
    end

    assign memAddr               = addr_ff;
    assign configWordOne         = rdData_ff;
    assign cfgSpaceGrant         = rdGrant_ff;
    assign debugEnable           = opt_ff[0];
    assign lowVoltProgEnable     = opt_ff[1];
    assign clockMonitorEnable    = opt_ff[2];
    assign clockSwitchoverEnable = opt_ff[3];
    assign brownoutModeSel       = opt_ff[5:4];
    assign brownoutActive        = borAct_ff;
    assign dataProtect           = opt_ff[6];
    assign programProtect        = opt_ff[7];
    assign extResetPinEnable     = opt_ff[8];
    assign powerupTimerEnable    = opt_ff[9];
    assign watchdogEnable        = wdtEn_ff;
    assign coreReset             = coreRst_ff;
    assign sleeping              = sleep_ff;
endmodule

/* File: hw/cwd_pkg.sv */
// constants for the configuration word decoder
package cwd_pkg;
    localparam logic [13:0] CFG_ADDR      = 14'h2007;
    localparam logic [13:0] CFG_SPACE_LO  = 14'h2000;
    localparam logic [15:0] ERASED_WORD   = 16'hffff;
    localparam int          WORD_W        = 14;
    localparam int          B_DEBUG       = 13;
    localparam int          B_LVP         = 12;
    localparam int          B_FCM         = 11;
    localparam int          B_CLOCK_SWITCHOVER_ENABLE        = 10;
    localparam int          B_BOR_HI      = 9;
    localparam int          B_BOR_LO      = 8;
    localparam int          B_CPD         = 7;
    localparam int          B_CP          = 6;
    localparam int          B_EXT_RESET_PIN_ENABLE       = 5;
    localparam int          B_POWERUP_TIMER_ENABLE_N       = 4;
    localparam int          B_WATCHDOG_ENABLE        = 3;
    localparam logic [1:0]  BOR_ON        = 2'h3;
    localparam logic [1:0]  BOR_RUN       = 2'h2;
    localparam logic [1:0]  BOR_SOFT      = 2'h1;
    localparam logic [1:0]  BOR_OFF       = 2'h0;
    localparam int          CLK_MHZ       = 100;
    localparam int          POWERUP_TIMER_MS       = 64;
    localparam int          POWERUP_TIMER_CYCLES   = POWERUP_TIMER_MS * 1000 * CLK_MHZ;
    localparam int          OST_CYCLES    = 1024;
    localparam int          SYNC_STAGES   = 3;
    typedef enum logic [2:0] {
        ST_FETCH,
        ST_OST,
        ST_POWERUP_TIMER,
        ST_RUN,
        ST_SLEEP
    } cwd_state_e;
endpackage

/* File: hw/cwd_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module cwd_sync (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);
    logic [cwd_pkg::SYNC_STAGES-1:0] stage_ff;
    logic [cwd_pkg::SYNC_STAGES-1:0] nxt_stage;
    logic                            out_ff;
    logic                            nxt_out;

    always_comb begin
        nxt_stage = {stage_ff[cwd_pkg::SYNC_STAGES-2:0], din};
        nxt_out   = out_ff;
        // stage 0 is only read by stage 1; filter looks at stages 1 and 2
        if (stage_ff[1] == stage_ff[2]) begin
            nxt_out = stage_ff[1];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            stage_ff <= '0;
            out_ff   <= 1'b0;
        end else begin
            stage_ff <= nxt_stage;
            out_ff   <= nxt_out;
        end
    end

    assign dout = out_ff;
endmodule

/* File: testbench/cwd_decoder_assertions.sv */
// concurrent checks on the configuration word decoder ports
`timescale 1ns/100ps
module cwd_decoder_checker #(
    parameter int POWERUP_TIMER_CYCLES = 20
) (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        progMode,
    input wire logic        cfgRdEn,
    input wire logic [13:0] cfgRdAddr,
    input wire logic        irqWake,
    input wire logic [13:0] memAddr,
    input wire logic [15:0] configWordOne,
    input wire logic        cfgSpaceGrant,
    input wire logic        debugEnable,
    input wire logic        lowVoltProgEnable,
    input wire logic        clockMonitorEnable,
    input wire logic        clockSwitchoverEnable,
    input wire logic [1:0]  brownoutModeSel,
    input wire logic        dataProtect,
    input wire logic        programProtect,
    input wire logic        extResetPinEnable,
    input wire logic        powerupTimerEnable,
    input wire logic        coreReset,
    input wire logic        sleeping
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [13:0] lastAddr;
    logic        hit;
    logic [9:0]  fields;
    always_ff @(posedge mclk) lastAddr <= cfgRdAddr;
    // a granted read of the word itself lets the decoded pins be compared to it
    assign hit = cfgSpaceGrant && !coreReset && lastAddr == 14'h2007;
    assign fields = {debugEnable, lowVoltProgEnable, clockMonitorEnable, clockSwitchoverEnable,
                     brownoutModeSel, dataProtect, programProtect, extResetPinEnable,
                     powerupTimerEnable};
    a_addr_fixed: assert property (memAddr == 14'h2007)
        else $error("fetch address moved");
    a_grant_cause: assert property (cfgSpaceGrant |->
        $past(progMode && cfgRdEn && cfgRdAddr >= 14'h2000)) else $error("grant without cause");
    a_denied_zero: assert property (!cfgSpaceGrant |-> configWordOne == 16'h0000)
        else $error("data shown without grant");
    a_top_bits_one: assert property (hit |-> configWordOne[15:14] == 2'h3)
        else $error("top bits not ones");
    a_debug_pins: assert property (hit |-> debugEnable == !configWordOne[13]
        && lowVoltProgEnable == configWordOne[12]) else $error("pin selects wrong");
    a_clock_opts: assert property (hit |->
        {clockMonitorEnable, clockSwitchoverEnable, brownoutModeSel} == configWordOne[11:8])
        else $error("clock or brown-out selects wrong");
    a_protect_bits: assert property (hit |-> {dataProtect, programProtect,
        extResetPinEnable, powerupTimerEnable} == {~configWordOne[7:6], configWordOne[5],
        ~configWordOne[4]}) else $error("protection or timer selects wrong");
    a_fields_hold: assert property (!coreReset && $past(!coreReset) |-> $stable(fields))
        else $error("decoded options changed while running");
    a_wake_bound: assert property (sleeping && irqWake |-> ##[1:8] !sleeping)
        else $error("interrupt did not wake");
    a_reset_core: assert property (disable iff (1'b0) !rst_n |=> coreReset)
        else $error("core not held in reset");
endmodule

bind cwd_decoder cwd_decoder_checker #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER_CYCLES)) u_cwd_decoder_checker (
    .mclk(mclk), .rst_n(rst_n), .progMode(progMode), .cfgRdEn(cfgRdEn), .cfgRdAddr(cfgRdAddr),
    .irqWake(irqWake), .memAddr(memAddr), .configWordOne(configWordOne),
    .cfgSpaceGrant(cfgSpaceGrant), .debugEnable(debugEnable),
    .lowVoltProgEnable(lowVoltProgEnable), .clockMonitorEnable(clockMonitorEnable),
    .clockSwitchoverEnable(clockSwitchoverEnable), .brownoutModeSel(brownoutModeSel),
    .dataProtect(dataProtect), .programProtect(programProtect),
    .extResetPinEnable(extResetPinEnable), .powerupTimerEnable(powerupTimerEnable),
    .coreReset(coreReset), .sleeping(sleeping)
);

/* File: testbench/cwd_decoder_bench.sv */
// self-checking bench for the configuration word decoder
`timescale 1ns/100ps
module cwd_decoder_bench;
    localparam int PW = 20;
    logic        mclk, rst_n, progMode, oscStable, extResetPin, brownoutDet, wdtWake, irqWake;
    logic        sleepReq, softBrownoutEnable, softWatchdogEnable, cfgRdEn, cfgSpaceGrant;
    logic        debugEnable, lowVoltProgEnable, clockMonitorEnable, clockSwitchoverEnable;
    logic        brownoutActive, dataProtect, programProtect, extResetPinEnable;
    logic        powerupTimerEnable, watchdogEnable, coreReset, sleeping;
    logic [1:0]  brownoutModeSel;
    logic [13:0] cfgRdAddr, memAddr, memData, word;
    logic [15:0] configWordOne;
    logic [15:0] expQ[$];
    int          n_errors = 0, checks = 0, seed = 85, n, lo;
    cwd_decoder #(.POWERUP_TIMER_CYCLES(PW)) u_cwd_decoder (
        .mclk(mclk), .rst_n(rst_n), .progMode(progMode), .memAddr(memAddr), .memData(memData),
        .oscStable(oscStable), .extResetPin(extResetPin), .brownoutDet(brownoutDet),
        .wdtWake(wdtWake), .irqWake(irqWake), .sleepReq(sleepReq),
        .softBrownoutEnable(softBrownoutEnable), .softWatchdogEnable(softWatchdogEnable),
        .cfgRdEn(cfgRdEn), .cfgRdAddr(cfgRdAddr), .configWordOne(configWordOne),
        .cfgSpaceGrant(cfgSpaceGrant), .debugEnable(debugEnable),
        .lowVoltProgEnable(lowVoltProgEnable), .clockMonitorEnable(clockMonitorEnable),
        .clockSwitchoverEnable(clockSwitchoverEnable), .brownoutModeSel(brownoutModeSel),
        .brownoutActive(brownoutActive), .dataProtect(dataProtect),
        .programProtect(programProtect), .extResetPinEnable(extResetPinEnable),
        .powerupTimerEnable(powerupTimerEnable), .watchdogEnable(watchdogEnable),
        .coreReset(coreReset), .sleeping(sleeping));
    cwd_prog_model u_cwd_prog_model (
        .mclk(mclk), .progWord(word), .memAddr(memAddr), .memData(memData));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // holds the request through the taking edge; the caller drops cfgRdEn afterwards
    task automatic rd(input logic [13:0] a, input logic pm);
        progMode <= pm;
        cfgRdEn <= 1'b1;
        cfgRdAddr <= a;
        if (pm && a >= 14'h2000) expQ.push_back(a == 14'h2007 ? {2'h3, word} : 16'h0);
        @(posedge mclk);
    endtask
    always @(posedge mclk) if (cfgSpaceGrant === 1'b1) begin
        if (expQ.size() == 0) check(16'h1, 16'h0);
        else check(configWordOne, expQ.pop_front());
    end
    initial begin mclk = 1'b0; forever #5 mclk = ~mclk; end
    initial begin #200000; n_errors++; tally_and_finish; end
    initial begin
        {rst_n, progMode, oscStable, extResetPin, brownoutDet, wdtWake, irqWake} = '0;
        {sleepReq, softBrownoutEnable, softWatchdogEnable, cfgRdEn} = '0;
        cfgRdAddr = '0;
        word = 14'h3fff;
        for (int i = 0; i < 5; i++) begin
            @(posedge mclk);
            rst_n <= 1'b0;
            progMode <= 1'b1;
            oscStable <= 1'b0;
            softWatchdogEnable <= 1'b0;
            // first pass keeps the erased word; later ones walk every brown-out mode
            if (i > 0) word <= (14'($random(seed)) & 14'h3cff) | (14'(i % 4) << 8);
            softBrownoutEnable <= 1'($random(seed));
            repeat (6) @(posedge mclk);
            rst_n <= 1'b1;
            repeat (4) @(posedge mclk);
            rd(14'h2007, 1'b1);
            rd(14'h1fff, 1'b1);
            rd(14'h2008, 1'b1);
            rd(14'h2007, 1'b0);
            cfgRdEn <= 1'b0;
            progMode <= 1'b0;
            repeat (4) @(posedge mclk);
            check(coreReset, 1'b1);
            check({debugEnable, lowVoltProgEnable, clockMonitorEnable, clockSwitchoverEnable,
                   brownoutModeSel, dataProtect, programProtect, extResetPinEnable,
                   powerupTimerEnable}, {~word[13], word[12:8], ~word[7:6], word[5],
                   ~word[4]});
            check(watchdogEnable, word[3]);
            softWatchdogEnable <= 1'b1;
            oscStable <= 1'b1;
            lo = 1024 + (word[4] ? 0 : PW);
            n = 0;
            while (coreReset !== 1'b0 && n < 2000) begin
                @(posedge mclk);
                n++;
            end
            check(n >= lo && n <= lo + 10, 1'b1);
            check(watchdogEnable, 1'b1);
            check(brownoutActive, word[9] | (word[8] & softBrownoutEnable));
            // a read while running lets the checker hold the decoded pins against the word
            rd(14'h2007, 1'b1);
            cfgRdEn <= 1'b0;
            progMode <= 1'b0;
            sleepReq <= 1'b1;
            @(posedge mclk);
            sleepReq <= 1'b0;
            @(posedge mclk);
            check(sleeping, 1'b1);
            check(brownoutActive, word[8] & (word[9] | softBrownoutEnable));
            if (i % 2) wdtWake <= 1'b1;
            else irqWake <= 1'b1;
            repeat (10) @(posedge mclk);
            check(sleeping, 1'b0);
            wdtWake <= 1'b0;
            irqWake <= 1'b0;
            extResetPin <= 1'b1;
            repeat (8) @(posedge mclk);
            check(coreReset, word[5]);
            extResetPin <= 1'b0;
            brownoutDet <= 1'b1;
            repeat (8) @(posedge mclk);
            check(coreReset, word[9] | (word[8] & softBrownoutEnable));
            brownoutDet <= 1'b0;
            // a tripped brown-out is stretched by the power-up timer when that is enabled
            lo = ((word[9] | (word[8] & softBrownoutEnable)) && !word[4]) ? PW : 0;
            n = 0;
            while (coreReset !== 1'b0 && n < 200) begin
                @(posedge mclk);
                n++;
            end
            check(n >= lo && n <= lo + 10, 1'b1);
        end
        repeat (4) @(posedge mclk);
        check(16'(expQ.size()), 16'h0);
        tally_and_finish;
    end
endmodule

/* File: testbench/cwd_prog_model.sv */
// configuration memory as left by the external programmer
`timescale 1ns/100ps
module cwd_prog_model (
    input  wire logic        mclk,
    input  wire logic [13:0] progWord,
    input  wire logic [13:0] memAddr,
    output logic [13:0]      memData
);
    logic [13:0] junk = 14'h2aaa;
    // other addresses toggle every cycle so a wrong fetch cannot pass by luck
    always_ff @(posedge mclk) junk <= ~junk;
    assign memData = (memAddr == 14'h2007) ? progWord : junk;
endmodule
